// ==== inc/pupc_regs.vh ====
// Register map, field positions, reset values and event codes of the performance counters
`ifndef PUPC_REGS_VH
`define PUPC_REGS_VH
// Word-index pages and single offsets
`define PUPC_PG_CTR 5'h00
`define PUPC_PG_CTL 6'h02
`define PUPC_OFF_FILT 8'h0C
`define PUPC_OFF_BOX 8'h0D
`define PUPC_PG_RES 5'h02
// Residency counter slots within the page
`define PUPC_RES_CC3 2'h0
`define PUPC_RES_CC6 2'h1
`define PUPC_RES_PC2 2'h2
`define PUPC_RES_PC3 2'h3
// Control fields
`define PUPC_CTL_EVSEL 7:0
`define PUPC_CTL_OCCFLAG 7
`define PUPC_CTL_OCCSEL 15:14
`define PUPC_CTL_RST 17
`define PUPC_CTL_EDGE 18
`define PUPC_CTL_EN 22
`define PUPC_CTL_INV 23
`define PUPC_CTL_THR 28:24
`define PUPC_CTL_OCCINV 30
`define PUPC_CTL_OCCEDGE 31
`define PUPC_CTL_WMASK 32'hDFF4C0FF
// Box control fields
`define PUPC_BOX_RSTCTL 0
`define PUPC_BOX_RSTCTR 1
`define PUPC_BOX_FRZ 8
// Reset values
`define PUPC_RST_CTL 32'h00000000
`define PUPC_RST_FILT 32'h00000000
`define PUPC_RST_CNT 48'h000000000000
`define PUPC_RST_RES 64'h0000000000000000
// Occupancy select codes
`define PUPC_OCC_C0 2'h1
`define PUPC_OCC_C3 2'h2
`define PUPC_OCC_C6 2'h3
`define PUPC_OCC_MAXINC 4'h8
`define PUPC_OCC_SAT 4'hF
// Event codes
`define PUPC_EV_TICKS 8'h00
`define PUPC_EV_VOLT 8'h03
`define PUPC_EV_THERM 8'h04
`define PUPC_EV_POWER 8'h05
`define PUPC_EV_OS 8'h06
`define PUPC_EV_HOTINT 8'h09
`define PUPC_EV_HOTEXT 8'h0A
`define PUPC_EV_BAND0 8'h0B
`define PUPC_EV_BAND1 8'h0C
`define PUPC_EV_BAND2 8'h0D
`define PUPC_EV_BAND3 8'h0E
`define PUPC_EV_PKG_C0 8'h2A
`define PUPC_EV_PKG_C2E 8'h2B
`define PUPC_EV_PKG_C3 8'h2C
`define PUPC_EV_PKG_C6 8'h2D
`define PUPC_EV_PKG_C7 8'h2E
`define PUPC_EV_MEMSHED 8'h2F
`define PUPC_EV_DEM_FIRST 8'h30
`define PUPC_EV_DEM_LAST 8'h41
`define PUPC_EV_VRHOT 8'h42
`define PUPC_EV_PKG_C1E 8'h4E
`define PUPC_EV_TRN_FIRST 8'h60
`define PUPC_EV_TRN_LAST 8'h71
`define PUPC_EV_TRN_ALL 8'h72
`define PUPC_EV_IOLOW 8'h73
`define PUPC_EV_FREQCHG 8'h74
`define PUPC_EV_OCC 8'h80
// Package state vector bits
`define PUPC_PKG_C0 0
`define PUPC_PKG_C2E 1
`define PUPC_PKG_C3 2
`define PUPC_PKG_C6 3
`define PUPC_PKG_C7 4
`define PUPC_PKG_C1E 5
`endif

// ==== verilog/pupc_top.v ====
// Power control unit performance counters: event counters, band filter, residency counters
// How it works
// [R1] Counters hold 48 bits, upper bits read zero
// [R2] Filter holds four 8-bit band values
// [R3] Band value is ratio in 100 MHz steps
// [R4] Four band residency events count simultaneously
// [R5] Software limits shared filter use per run
// [R6] Four read-only 64-bit residency counters
// [R7] Residency counters ignore freeze and box resets
// [R8] Core residency adds one if any core
// [R9] Three 4-bit cores-in-state occupancy counts
// [R10] Occupancy event adds up to eight
// [R11] Package residency event codes and C1E
// [R12] Per-core demotion events 0x30 to 0x41
// [R13] Per-core transition cycles, plus total 0x72
// [R14] Frequency limit cycles: thermal, power, OS
// [R15] Frequency change and IO lower limit
// [R16] Memory phase shedding cycles event
// [R17] Edge detect turns cycles into transitions
// [R18] Event 0x03 counts voltage transition cycles
// [R19] Threshold five on C0 occupancy works
// [R20] Occupancy edge counts entries past threshold
// [R21] Inverted threshold and band filter work
// [R22] Occupancy select picks C0, C3, C6
// [R23] Bit 7 selects occupancy flags
// [R24] Threshold test greater-equal, invert less-than
// [R25] Counter wraps past bit 47
// [R26] Enabled unfrozen counter adds qualified increment
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "pupc_regs.vh"
module pupc_top #(
    parameter NUM_CORES = 18
) (
    input wire sys_clk, // Unit clock
    input wire rst, // Async reset, active high
    input wire [7:0] regAddr, // Register word index
    input wire [31:0] regWrData, // Write data
    input wire regWr, // Write strobe
    input wire regRd, // Read strobe
    output reg [31:0] regRdData_q, // Read data, cycle after strobe
    input wire [NUM_CORES-1:0] coreInC0, // Core is in C0
    input wire [NUM_CORES-1:0] coreInC3, // Core is in C3
    input wire [NUM_CORES-1:0] coreInC6, // Core is in C6
    input wire [NUM_CORES-1:0] coreDemote, // Core demotion pulse
    input wire [NUM_CORES-1:0] coreTrans, // Core state transition busy
    input wire [5:0] pkgState, // Package state, one bit per state
    input wire [7:0] curRatio, // Operating ratio, 100 MHz steps
    input wire voltTrans, // Voltage transition busy
    input wire freqTrans, // Frequency change busy
    input wire [2:0] freqLimit, // Upper limit: thermal, power, OS
    input wire ioLowLimit, // IO lower limit strongest
    input wire memShed, // Memory phase shedding active
    input wire prochotInt, // Internal hot throttle
    input wire prochotExt, // External hot throttle
    input wire vrHot // Regulator hot
);

    // Saturating population count for occupancy
    // More than fifteen cores in one state would overflow a 4-bit count,
    // so the count sticks at its top value instead of wrapping
    function [3:0] popSat;
        input [NUM_CORES-1:0] v;
        integer k;
        integer s;
        begin
            s = 0;
            for (k = 0; k < NUM_CORES; k = k + 1) begin
                s = s + v[k];
            end
            if (s > 15) begin
                popSat = `PUPC_OCC_SAT;
            end else begin
                popSat = s[3:0];
            end
        end
    endfunction

    // Monitoring counters, their controls, the band filter and the freeze flag
    reg [47:0] cnt_q [0:3];
    reg [31:0] ctl_q [0:3];
    reg [31:0] filt_q;
    reg frz_q;
    // Free-running residency counters, never touched by software
    reg [63:0] resCc3_q;
    reg [63:0] resCc6_q;
    reg [63:0] resPc2_q;
    reg [63:0] resPc3_q;
    // Registered cores-in-state counts; occupancy events lag the pins by one cycle
    reg [3:0] occC0_q;
    reg [3:0] occC3_q;
    reg [3:0] occC6_q;
    // Last cycle's threshold result per counter, for edge detection
    reg [3:0] prevCmp_q;
    // Per-counter increment after threshold, invert and edge shaping
    reg [3:0] qInc [0:3];
    reg [3:0] cmpNow;
    reg [7:0] code;
    reg [7:0] idx;
    reg [3:0] raw;
    reg [4:0] thr;
    reg inv;
    reg edg;
    reg cmp;
    reg [31:0] rdMux_d;
    // Loop index of the combinational shaping only
    integer i;
    // Loop index of the clocked counter process; kept apart so each has one driver
    integer j;

    // Per-core pulses padded to a full word so any index in the code range is legal
    // Indices past the last core read zero, so unused codes count nothing
    wire [31:0] demoteW = {{(32-NUM_CORES){1'b0}}, coreDemote};
    wire [31:0] transW = {{(32-NUM_CORES){1'b0}}, coreTrans};
    // Register write decodes; the box word carries the shared reset actions
    wire wrCtr = regWr && (regAddr[7:3] == `PUPC_PG_CTR);
    wire wrCtl = regWr && (regAddr[7:2] == `PUPC_PG_CTL);
    wire wrFilt = regWr && (regAddr == `PUPC_OFF_FILT);
    wire wrBox = regWr && (regAddr == `PUPC_OFF_BOX);
    wire boxRstCtr = wrBox && regWrData[`PUPC_BOX_RSTCTR];
    wire boxRstCtl = wrBox && regWrData[`PUPC_BOX_RSTCTL];

    // Raw event selection and threshold, invert, edge shaping per counter
    // All four counters share one event decoder body, unrolled by the loop,
    // so every event can be counted on any of the four counters
    always @* begin
        code = 8'h00;
        idx = 8'h00;
        raw = 4'h0;
        thr = 5'h00;
        inv = 1'b0;
        edg = 1'b0;
        cmp = 1'b0;
        cmpNow = 4'h0;
        for (i = 0; i < 4; i = i + 1) begin
            code = ctl_q[i][`PUPC_CTL_EVSEL];
            raw = 4'h0;
            if (code >= `PUPC_EV_DEM_FIRST && code <= `PUPC_EV_DEM_LAST) begin
                idx = code - `PUPC_EV_DEM_FIRST;
                raw = {3'h0, demoteW[idx[4:0]]}; // see [R12]
            end else if (code >= `PUPC_EV_TRN_FIRST && code <= `PUPC_EV_TRN_LAST) begin
                idx = code - `PUPC_EV_TRN_FIRST;
                raw = {3'h0, transW[idx[4:0]]}; // see [R13]
            end else begin
                case (code)
                    `PUPC_EV_TICKS: raw = 4'h1;
                    `PUPC_EV_VOLT: raw = {3'h0, voltTrans}; // see [R18]
                    `PUPC_EV_THERM: raw = {3'h0, freqLimit[0]}; // see [R14]
                    `PUPC_EV_POWER: raw = {3'h0, freqLimit[1]}; // see [R14]
                    `PUPC_EV_OS: raw = {3'h0, freqLimit[2]}; // see [R14]
                    `PUPC_EV_HOTINT: raw = {3'h0, prochotInt};
                    `PUPC_EV_HOTEXT: raw = {3'h0, prochotExt};
                    // Band n active while ratio is below its value
                    `PUPC_EV_BAND0: raw = {3'h0, curRatio < filt_q[7:0]}; // see [R3] [R4] [R21]
                    `PUPC_EV_BAND1: raw = {3'h0, curRatio < filt_q[15:8]}; // see [R4]
                    `PUPC_EV_BAND2: raw = {3'h0, curRatio < filt_q[23:16]}; // see [R4]
                    `PUPC_EV_BAND3: raw = {3'h0, curRatio < filt_q[31:24]}; // see [R4]
                    `PUPC_EV_PKG_C0: raw = {3'h0, pkgState[`PUPC_PKG_C0]}; // see [R11]
                    `PUPC_EV_PKG_C2E: raw = {3'h0, pkgState[`PUPC_PKG_C2E]}; // see [R11]
                    `PUPC_EV_PKG_C3: raw = {3'h0, pkgState[`PUPC_PKG_C3]}; // see [R11]
                    `PUPC_EV_PKG_C6: raw = {3'h0, pkgState[`PUPC_PKG_C6]}; // see [R11]
                    `PUPC_EV_PKG_C7: raw = {3'h0, pkgState[`PUPC_PKG_C7]}; // see [R11]
                    `PUPC_EV_PKG_C1E: raw = {3'h0, pkgState[`PUPC_PKG_C1E]}; // see [R11]
                    `PUPC_EV_MEMSHED: raw = {3'h0, memShed}; // see [R16]
                    `PUPC_EV_VRHOT: raw = {3'h0, vrHot};
                    `PUPC_EV_TRN_ALL: raw = {3'h0, |coreTrans}; // see [R13]
                    `PUPC_EV_IOLOW: raw = {3'h0, ioLowLimit}; // see [R15]
                    `PUPC_EV_FREQCHG: raw = {3'h0, freqTrans}; // see [R15]
                    `PUPC_EV_OCC: begin
                        // Occupancy count of the selected state, capped per cycle
                        case (ctl_q[i][`PUPC_CTL_OCCSEL])
                            `PUPC_OCC_C0: raw = occC0_q; // see [R22]
                            `PUPC_OCC_C3: raw = occC3_q; // see [R22]
                            `PUPC_OCC_C6: raw = occC6_q; // see [R22]
                            default: raw = 4'h0;
                        endcase
                        if (raw > `PUPC_OCC_MAXINC) begin
                            raw = `PUPC_OCC_MAXINC; // see [R10]
                        end
                    end
                    default: raw = 4'h0;
                endcase
            end
            thr = ctl_q[i][`PUPC_CTL_THR];
            // Occupancy events use their own invert and edge flags
            if (code[`PUPC_CTL_OCCFLAG]) begin
                inv = ctl_q[i][`PUPC_CTL_OCCINV]; // see [R23]
                edg = ctl_q[i][`PUPC_CTL_OCCEDGE]; // see [R23]
            end else begin
                inv = ctl_q[i][`PUPC_CTL_INV];
                edg = ctl_q[i][`PUPC_CTL_EDGE];
            end
            // Threshold test, with zero threshold meaning any activity
            // The test sees the increment of this cycle, not the running count
            if (thr == 5'h00) begin
                cmp = (raw != 4'h0);
            end else if (inv) begin
                cmp = ({1'b0, raw} < thr); // see [R24] [R21]
            end else begin
                cmp = ({1'b0, raw} >= thr); // see [R24] [R19]
            end
            cmpNow[i] = cmp;
            // Edge mode counts only the cycles where the test result turns true;
            // with invert set this is the falling edge of the plain test
            if (edg) begin
                qInc[i] = {3'h0, cmp & ~prevCmp_q[i]}; // see [R17] [R20]
            end else if (thr != 5'h00) begin
                qInc[i] = {3'h0, cmp};
            end else begin
                qInc[i] = raw; // see [R10]
            end
        end
    end

    // Monitoring counters and their controls
    // Priority per counter: reset, then software write, then counting, so a
    // write always lands as written even while the event is active
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (j = 0; j < 4; j = j + 1) begin
                cnt_q[j] <= `PUPC_RST_CNT;
                ctl_q[j] <= `PUPC_RST_CTL;
            end
            prevCmp_q <= 4'h0;
        end else begin
            prevCmp_q <= cmpNow;
            for (j = 0; j < 4; j = j + 1) begin
                if (boxRstCtl) begin
                    ctl_q[j] <= `PUPC_RST_CTL;
                end else if (wrCtl && regAddr[1:0] == j[1:0]) begin
                    // Reserved and write-only bits never reach the stored control
                    ctl_q[j] <= regWrData & `PUPC_CTL_WMASK;
                end
                if (boxRstCtr || (wrCtl && regAddr[1:0] == j[1:0] && regWrData[`PUPC_CTL_RST])) begin
                    cnt_q[j] <= `PUPC_RST_CNT;
                end else if (wrCtr && regAddr[2:1] == j[1:0]) begin
                    // Halves are written on their own; the other half keeps its value
                    if (regAddr[0]) begin
                        cnt_q[j][47:32] <= regWrData[15:0]; // see [R1]
                    end else begin
                        cnt_q[j][31:0] <= regWrData; // see [R1]
                    end
                end else if (ctl_q[j][`PUPC_CTL_EN] && !frz_q) begin
                    // Carry out of bit 47 is dropped so the count wraps
                    cnt_q[j] <= cnt_q[j] + {44'h0, qInc[j]}; // see [R26] [R25]
                end
            end
        end
    end

    // Filter and freeze state
    // The filter is shared by all band events; freeze stops only monitor counters
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            filt_q <= `PUPC_RST_FILT;
            frz_q <= 1'b0;
        end else begin
            if (wrFilt) begin
                filt_q <= regWrData; // see [R2]
            end
            if (wrBox) begin
                frz_q <= regWrData[`PUPC_BOX_FRZ];
            end
        end
    end

    // Occupancy sub-counters, refreshed every cycle
    // Registering them keeps the wide population count off the counter adders
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            occC0_q <= 4'h0;
            occC3_q <= 4'h0;
            occC6_q <= 4'h0;
        end else begin
            occC0_q <= popSat(coreInC0); // see [R9]
            occC3_q <= popSat(coreInC3); // see [R9]
            occC6_q <= popSat(coreInC6); // see [R9]
        end
    end

    // Free-running residency counters, untouched by software or freeze
    // Core counters add one when any core is in the state, not the core count
    // Only the chip reset clears them; box resets and writes have no path here
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            resCc3_q <= `PUPC_RST_RES;
            resCc6_q <= `PUPC_RST_RES;
            resPc2_q <= `PUPC_RST_RES;
            resPc3_q <= `PUPC_RST_RES;
        end else begin
            resCc3_q <= resCc3_q + {63'h0, |coreInC3}; // see [R6] [R7] [R8]
            resCc6_q <= resCc6_q + {63'h0, |coreInC6}; // see [R6] [R7] [R8]
            resPc2_q <= resPc2_q + {63'h0, pkgState[`PUPC_PKG_C2E]}; // see [R6] [R7]
            resPc3_q <= resPc3_q + {63'h0, pkgState[`PUPC_PKG_C3]}; // see [R6] [R7]
        end
    end

    // Read multiplexer; unmapped words read zero
    // Wide counters are read as two words and the pair is not latched, so
    // software must allow for a carry between the two reads
    always @* begin
        rdMux_d = 32'h00000000;
        if (regAddr[7:3] == `PUPC_PG_CTR) begin
            if (regAddr[0]) begin
                rdMux_d = {16'h0000, cnt_q[regAddr[2:1]][47:32]}; // see [R1]
            end else begin
                rdMux_d = cnt_q[regAddr[2:1]][31:0];
            end
        end else if (regAddr[7:2] == `PUPC_PG_CTL) begin
            rdMux_d = ctl_q[regAddr[1:0]];
        end else if (regAddr == `PUPC_OFF_FILT) begin
            rdMux_d = filt_q;
        end else if (regAddr == `PUPC_OFF_BOX) begin
            rdMux_d = {23'h000000, frz_q, 8'h00};
        end else if (regAddr[7:3] == `PUPC_PG_RES) begin
            case (regAddr[2:1])
                `PUPC_RES_CC3: rdMux_d = regAddr[0] ? resCc3_q[63:32] : resCc3_q[31:0];
                `PUPC_RES_CC6: rdMux_d = regAddr[0] ? resCc6_q[63:32] : resCc6_q[31:0];
                `PUPC_RES_PC2: rdMux_d = regAddr[0] ? resPc2_q[63:32] : resPc2_q[31:0];
                `PUPC_RES_PC3: rdMux_d = regAddr[0] ? resPc3_q[63:32] : resPc3_q[31:0];
                default: rdMux_d = 32'h00000000;
            endcase
        end
    end

    // Read data stands only in the cycle after the strobe
    // Returning zero otherwise keeps stale counter values off the bus
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            regRdData_q <= 32'h00000000;
        end else if (regRd) begin
            regRdData_q <= rdMux_d;
        end else begin
            regRdData_q <= 32'h00000000;
        end
    end

endmodule // pupc_top

// ==== sim/pupc_checker.sv ====
// Concurrent checks on the register port of the performance counters
`timescale 1ns/1ps
`include "pupc_regs.vh"
module pupc_checker #(
    parameter NUM_CORES = 18
) (
    input wire sys_clk, // Unit clock
    input wire rst, // Async reset, active high
    input wire [7:0] regAddr, // Register word index
    input wire [31:0] regWrData, // Write data
    input wire regWr, // Write strobe
    input wire regRd, // Read strobe
    input wire [31:0] regRdData_q, // Read data
    input wire [NUM_CORES-1:0] coreInC3, // Cores in C3
    input wire [NUM_CORES-1:0] coreInC6, // Cores in C6
    input wire [5:0] pkgState // Package state
);
    // Any-core flags feeding the residency steps
    wire anyC3 = |coreInC3;
    wire anyC6 = |coreInC6;
    wire pkgC3 = pkgState[`PUPC_PKG_C3];
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    rd_idle_zero_a: assert property (!regRd |=> regRdData_q == 32'h0)
        else $error("read data not zero outside a read");
    ctr_low_rw_a: assert property (regWr && regAddr < 8'h08 && !regAddr[0] ##1 regRd && regAddr == $past(regAddr)
        |=> regRdData_q == $past(regWrData, 2)) else $error("counter low word lost the write");
    ctr_hi_zero_a: assert property (regRd && regAddr < 8'h08 && regAddr[0] |=> regRdData_q[31:16] == 16'h0)
        else $error("counter upper bits not zero");
    filt_rw_a: assert property (regWr && regAddr == 8'h0C ##1 regRd && regAddr == 8'h0C
        |=> regRdData_q == $past(regWrData, 2)) else $error("band filter lost the write");
    ctl_rw_a: assert property (regWr && regAddr[7:2] == 6'h02 ##1 regRd && regAddr == $past(regAddr)
        |=> regRdData_q == ($past(regWrData, 2) & `PUPC_CTL_WMASK)) else $error("control readback wrong");
    unmap_zero_a: assert property (regRd && (regAddr > 8'h17 || regAddr[7:1] == 7'h07)
        |=> regRdData_q == 32'h0) else $error("unmapped read not zero");
    cc3_step_a: assert property (regRd && regAddr == 8'h10 ##1 regRd && regAddr == 8'h10
        |=> regRdData_q == $past(regRdData_q) + {31'h0, $past(anyC3, 2)}) else $error("core C3 residency step wrong");
    pc3_step_a: assert property (regRd && regAddr == 8'h16 ##1 regRd && regAddr == 8'h16
        |=> regRdData_q == $past(regRdData_q) + {31'h0, $past(pkgC3, 2)}) else $error("package C3 residency step wrong");
    cc6_nowr_a: assert property (regRd && regAddr == 8'h12 ##1 regWr && regAddr == 8'h12 ##1 regRd && regAddr == 8'h12
        |=> regRdData_q == $past(regRdData_q, 2) + {31'h0, $past(anyC6, 3)} + {31'h0, $past(anyC6, 2)})
        else $error("core C6 residency altered by write");
endmodule // pupc_checker

// ==== sim/tb_top.sv ====
// Self-checking bench for the power unit performance counters
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin errCount++; $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
    localparam logic [127:0] CODES = 128'h4E2E2D2C2B2A420A092F7306050474_03;
    localparam logic [31:0] EN = 32'h00400000;
    logic sys_clk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0, rdLate = 1'b0;
    logic [7:0] regAddr = 8'h00, curRatio = 8'hFF, code;
    logic [31:0] regWrData = 32'h0, tmp, e0, m0;
    wire [31:0] regRdData_q;
    logic [17:0] coreInC0 = 18'h0, coreInC3 = 18'h0, coreInC6 = 18'h0;
    logic [63:0] stim = 64'h0;
    logic [31:0] expQ[$], mskQ[$];
    int errCount = 0, comparisons = 0, seedVal, k;
    pupc_top dut_u (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData_q(regRdData_q), .coreInC0(coreInC0), .coreInC3(coreInC3), .coreInC6(coreInC6),
        .coreDemote(stim[33:16]), .coreTrans(stim[51:34]), .pkgState(stim[15:10]), .curRatio(curRatio),
        .voltTrans(stim[0]), .freqTrans(stim[1]), .freqLimit(stim[4:2]), .ioLowLimit(stim[5]),
        .memShed(stim[6]), .prochotInt(stim[7]), .prochotExt(stim[8]), .vrHot(stim[9]));
    // Unit clock, 20 ns period
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    // Read data stands in the cycle after the strobe; compare it against the oldest note
    always @(posedge sys_clk) rdLate <= regRd;
    always @(negedge sys_clk) begin
        if (rdLate) begin
            e0 = expQ.pop_front();
            m0 = mskQ.pop_front();
            `CHK(regRdData_q & m0, e0 & m0)
        end
    end
    // One bus cycle, launched just after an edge
    task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic w, input logic r);
        regAddr <= a;
        regWrData <= d;
        regWr <= w;
        regRd <= r;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        expQ.push_back(e);
        mskQ.push_back(m);
        bus(a, 32'h0, 1'b0, 1'b1);
    endtask
    task automatic idle(input int n);
        repeat (n) bus(8'h00, 32'h0, 1'b0, 1'b0);
    endtask
    // Program a counter, hold an event for k cycles, read both halves back
    task automatic ev_run(input int n, input logic [31:0] ctl, input logic [63:0] m, input int k,
        input logic [47:0] pre, input logic [47:0] e);
        bus(8'h08 + n[7:0], ctl, 1'b1, 1'b0);
        bus({n[6:0], 1'b0}, pre[31:0], 1'b1, 1'b0);
        bus({n[6:0], 1'b1}, {16'h0, pre[47:32]}, 1'b1, 1'b0);
        stim <= m;
        idle(k);
        stim <= 64'h0;
        idle(3);
        rd({n[6:0], 1'b0}, e[31:0], '1);
        rd({n[6:0], 1'b1}, {16'h0, e[47:32]}, '1);
        bus(8'h08 + n[7:0], 32'h0, 1'b1, 1'b0);
        idle(1);
    endtask
    task automatic close_out;
        if (errCount == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Cuts a hang short
    initial begin
        repeat (20000) @(posedge sys_clk);
        errCount++;
        close_out();
    end
    // Main sequence
    initial begin
        seedVal = $urandom(73);
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        for (int a = 0; a < 26; a++) rd(a[7:0], 32'h0, '1);
        tmp = $urandom();
        bus(8'h0C, tmp, 1'b1, 1'b0);
        rd(8'h0C, tmp, '1);
        bus(8'h01, tmp, 1'b1, 1'b0);
        rd(8'h01, tmp & 32'hFFFF, '1);
        bus(8'h06, tmp, 1'b1, 1'b0);
        rd(8'h06, tmp, '1);
        bus(8'h09, tmp, 1'b1, 1'b0);
        rd(8'h09, tmp & 32'hDFF4C0FF, '1);
        bus(8'h09, 32'h0, 1'b1, 1'b0);
        bus(8'h10, tmp, 1'b1, 1'b0);
        bus(8'h18, tmp, 1'b1, 1'b0);
        rd(8'h10, 32'h0, '1);
        rd(8'h18, 32'h0, '1);
        // Every single-bit event except ticks, the four band events and 0x72, counted plain and with edge detection
        for (int i = 0; i < 52; i++) begin
            code = i < 16 ? CODES[i*8 +: 8] : (i < 34 ? 8'h30 + i[7:0] - 8'd16 : 8'h60 + i[7:0] - 8'd34);
            k = $urandom_range(6, 1);
            ev_run(i % 4, EN | {24'h0, code}, 64'h1 << i, k, 48'h0, {16'h0, k});
            ev_run(i % 4, EN | 32'h01040000 | {24'h0, code}, 64'h1 << i, k, 48'h0, 48'h1);
        end
        ev_run(1, EN | 32'h72, (64'h1 << 34) | (64'h1 << 40), 4, 48'h0, 48'h4);
        ev_run(2, EN | 32'h03, 64'h1, 2, 48'hFFFFFFFFFFFF, 48'h1);
        // Freeze holds the monitor counters while residency keeps running
        bus(8'h0D, 32'h100, 1'b1, 1'b0);
        ev_run(3, EN | 32'h03, 64'h1, 3, 48'h5, 48'h5);
        coreInC3 <= 18'h1;
        coreInC6 <= 18'h2;
        stim <= 64'h1000;
        rd(8'h10, 32'h0, '1);
        rd(8'h10, 32'h1, '1);
        rd(8'h12, 32'h2, '1);
        bus(8'h12, $urandom(), 1'b1, 1'b0);
        rd(8'h12, 32'h4, '1);
        rd(8'h16, 32'h0, 32'h0);
        rd(8'h16, 32'h0, 32'h0);
        coreInC3 <= 18'h0;
        coreInC6 <= 18'h0;
        stim <= 64'h0;
        bus(8'h0D, 32'h0, 1'b1, 1'b0);
        // Four bands at once, ratio on the band zero boundary
        bus(8'h0C, 32'h30282014, 1'b1, 1'b0); // filter serves only the band events
        for (int n = 0; n < 4; n++) begin
            bus(8'h08 + n[7:0], EN | 32'h0B + n, 1'b1, 1'b0);
            bus({n[6:0], 1'b0}, 32'h0, 1'b1, 1'b0);
        end
        k = $urandom_range(9, 2);
        curRatio <= 8'h14;
        idle(k);
        curRatio <= 8'hFF;
        idle(3);
        rd(8'h00, 32'h0, '1);
        for (int n = 1; n < 4; n++) rd({n[6:0], 1'b0}, k, '1);
        // Occupancy: capped raw sum, threshold, edge and C3 selection
        bus(8'h08, EN | 32'h4080, 1'b1, 1'b0);
        bus(8'h09, EN | 32'h05004080, 1'b1, 1'b0);
        bus(8'h0A, EN | 32'h85004080, 1'b1, 1'b0);
        bus(8'h0B, EN | 32'h8080, 1'b1, 1'b0);
        for (int n = 0; n < 4; n++) bus({n[6:0], 1'b0}, 32'h0, 1'b1, 1'b0);
        coreInC0 <= 18'h3FFFF;
        coreInC3 <= 18'h1C0;
        idle(k);
        coreInC0 <= 18'h0;
        coreInC3 <= 18'h0;
        idle(4);
        rd(8'h00, 8 * k, '1);
        rd(8'h02, k, '1);
        rd(8'h04, 32'h1, '1);
        rd(8'h06, 3 * k, '1);
        // Inverted threshold below four cores, and C6 selection
        coreInC0 <= 18'h3F;
        idle(3);
        bus(8'h08, EN | 32'h44804080, 1'b1, 1'b0);
        bus(8'h09, EN | 32'hC080, 1'b1, 1'b0);
        bus(8'h00, 32'h0, 1'b1, 1'b0);
        bus(8'h02, 32'h0, 1'b1, 1'b0);
        coreInC0 <= 18'h7;
        coreInC6 <= 18'h3;
        idle(k);
        coreInC0 <= 18'h3F;
        coreInC6 <= 18'h0;
        idle(4);
        rd(8'h00, k, '1);
        rd(8'h02, 2 * k, '1);
        // Control reset bit, box counter reset and box control reset
        bus(8'h09, EN | 32'h0002C080, 1'b1, 1'b0);
        rd(8'h02, 32'h0, '1);
        rd(8'h09, EN | 32'hC080, '1);
        bus(8'h0D, 32'h2, 1'b1, 1'b0);
        rd(8'h00, 32'h0, '1);
        bus(8'h0D, 32'h1, 1'b1, 1'b0);
        rd(8'h08, 32'h0, '1);
        idle(2);
        close_out();
    end
endmodule // tb_top
bind pupc_top pupc_checker #(.NUM_CORES(NUM_CORES)) chk_u (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData_q(regRdData_q), .coreInC3(coreInC3),
    .coreInC6(coreInC6), .pkgState(pkgState));
